// ### include/sensorless_load_stall_detect_consts.vh
// constants for the sensorless load measurement and stall detector
// assumes inclusion by bare name from every design file of the block
`ifndef SENSORLESS_LOAD_STALL_DETECT_CONSTS_VH
`define SENSORLESS_LOAD_STALL_DETECT_CONSTS_VH

// register addresses on the plain configuration port
`define SLSD_ADDR_CTRL 3'h0
`define SLSD_ADDR_LOWER_VEL 3'h1
`define SLSD_ADDR_UPPER_VEL 3'h2
`define SLSD_ADDR_STATUS 3'h3
`define SLSD_ADDR_INTERVAL 3'h4

// control register fields
`define SLSD_CTRL_THR_LSB 0
`define SLSD_CTRL_THR_MSB 6
`define SLSD_CTRL_FILT_BIT 8
`define SLSD_CTRL_DIAG_ZERO_BIT 9
`define SLSD_CTRL_DIAG_ONE_BIT 10

// status register fields
`define SLSD_STAT_LOAD_LSB 0
`define SLSD_STAT_LOAD_MSB 9
`define SLSD_STAT_STALL_BIT 16

// reset values
`define SLSD_RST_THR 7'h00
`define SLSD_RST_FILT 1'b0
`define SLSD_RST_DIAG 1'b0
`define SLSD_RST_VEL 20'h00000
`define SLSD_RST_LOAD 10'h000

// widths and timing
`define SLSD_VEL_W 20
`define SLSD_LOAD_W 10
`define SLSD_LOAD_MAX 10'h3FF
`define SLSD_INTERVAL_MAX 20'hFFFFF
`define SLSD_THR_SHIFT 3
`define SLSD_TICK_DIV 16
`define SLSD_FILT_LEN 4

`endif

// ### src/load_filter.v
// optional four-sample mean of the threshold-offset load measurement
// assumes sample_i is a one-cycle pulse on the block clock
`timescale 1ns/100ps
`default_nettype none
`include "sensorless_load_stall_detect_consts.vh"

module load_filter #(
   parameter LOAD_W = `SLSD_LOAD_W
) (
   input wire clk_i, // block clock
   input wire rst_b_i, // async reset, active low
   input wire filt_en_i, // 1: average four samples
   input wire sample_i, // new measurement strobe
   input wire [LOAD_W-1:0] data_i, // measurement value
   output wire valid_o, // result strobe
   output wire [LOAD_W-1:0] data_o // result value
);

   reg [1:0] cnt_ff;
   reg [LOAD_W+1:0] acc_ff;
   reg filt_q_ff;
   wire [LOAD_W+1:0] sum;

   assign sum = acc_ff + {2'b00, data_i};

   // accumulate four samples; a mode change restarts the group
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_ff <= 2'h0;
         acc_ff <= {(LOAD_W+2){1'b0}};
         filt_q_ff <= 1'b0;
      end else begin
         filt_q_ff <= filt_en_i;
         if (filt_q_ff != filt_en_i || !filt_en_i) begin
            cnt_ff <= 2'h0;
            acc_ff <= {(LOAD_W+2){1'b0}};
         end else if (sample_i) begin
            cnt_ff <= cnt_ff + 2'h1;
            acc_ff <= (cnt_ff == 2'h3) ? {(LOAD_W+2){1'b0}} : sum;
         end
      end
   end

   // unfiltered: every sample; filtered: one per four full steps
   assign valid_o = sample_i && (!filt_en_i ||
                    (filt_q_ff == filt_en_i && cnt_ff == 2'h3));
   assign data_o = filt_en_i ? sum[LOAD_W+1:2] : data_i;

endmodule // load_filter
`default_nettype wire

// ### src/sensorless_load_stall_detect.v
// sensorless load measurement and stall detection for a stepper driver
// assumes full-step strobe and raw load value come from on-chip logic on CLK_I
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sensorless_load_stall_detect_consts.vh"

module sensorless_load_stall_detect #(
   parameter TICK_DIV = `SLSD_TICK_DIV,
   parameter VEL_W = `SLSD_VEL_W,
   parameter LOAD_W = `SLSD_LOAD_W
) (
   input wire CLK_I, // 200 MHz block clock
   input wire RST_B_I, // async reset, active low
   input wire [2:0] REG_ADDR_I, // register address
   input wire [31:0] REG_WDATA_I, // write data
   input wire REG_WR_I, // write strobe
   input wire REG_RD_I, // read strobe
   output wire [31:0] REG_RDATA_O, // read data, cycle after strobe
   input wire FULLSTEP_I, // one pulse per full step
   input wire [LOAD_W-1:0] RAW_LOAD_I, // raw load sample at full step
   output wire DIAG_OUT_ZERO_O, // diagnostic output zero
   output wire DIAG_OUT_ONE_O, // diagnostic output one
   output wire [LOAD_W-1:0] LOAD_RESULT_O, // current load result
   output wire STALL_O // stall indication
);

   // configuration registers
   reg [6:0] stall_threshold_ff;
   reg filt_en_ff;
   reg diag_zero_en_ff;
   reg diag_one_en_ff;
   reg [VEL_W-1:0] lower_velocity_limit_ff;
   reg [VEL_W-1:0] upper_velocity_limit_ff;

   // state
   reg [LOAD_W-1:0] load_result_ff;
   reg stall_ff;
   reg diag_zero_ff;
   reg diag_one_ff;
   reg [31:0] rdata_ff;
   reg [31:0] nxt_rdata;
   reg nxt_stall;

   wire [VEL_W-1:0] step_interval_measure;
   wire [LOAD_W-1:0] comp_load;
   wire filt_valid;
   wire [LOAD_W-1:0] filt_data;
   wire in_window;
   wire slow_side;
   wire fast_side;

   // shift the raw sample by the signed threshold and clamp to range
   function [LOAD_W-1:0] apply_threshold;
      input [LOAD_W-1:0] raw;
      input [6:0] thr;
      reg [LOAD_W+1:0] ext;
      reg [LOAD_W+1:0] off;
      reg [LOAD_W+1:0] tot;
      begin
         ext = {2'b00, raw};
         off = {{(LOAD_W+2-7){thr[6]}}, thr} << `SLSD_THR_SHIFT;
         tot = ext + off;
         if (tot[LOAD_W+1]) begin
            apply_threshold = {LOAD_W{1'b0}}; // below zero clamps at zero load
         end else if (tot[LOAD_W]) begin
            apply_threshold = {LOAD_W{1'b1}};
         end else begin
            apply_threshold = tot[LOAD_W-1:0];
         end
      end
   endfunction

   // threshold offset: higher setting lifts the result, needs more torque
   assign comp_load = apply_threshold(RAW_LOAD_I, stall_threshold_ff);

   step_interval_meter #(
      .TICK_DIV(TICK_DIV),
      .VEL_W(VEL_W)
   ) u_interval (
      .clk_i(CLK_I),
      .rst_b_i(RST_B_I),
      .fullstep_i(FULLSTEP_I),
      .interval_o(step_interval_measure)
   );

   load_filter #(
      .LOAD_W(LOAD_W)
   ) u_filter (
      .clk_i(CLK_I),
      .rst_b_i(RST_B_I),
      .filt_en_i(filt_en_ff),
      .sample_i(FULLSTEP_I),
      .data_i(comp_load),
      .valid_o(filt_valid),
      .data_o(filt_data)
   );

   // interval is inverse velocity: long interval means slow motor
   assign slow_side = (step_interval_measure > lower_velocity_limit_ff);
   assign fast_side = (step_interval_measure < upper_velocity_limit_ff);
   // reset limits of zero keep detection off until software sets a window
   assign in_window = !slow_side && !fast_side;

   // register writes
   always @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         stall_threshold_ff <= `SLSD_RST_THR;
         filt_en_ff <= `SLSD_RST_FILT;
         diag_zero_en_ff <= `SLSD_RST_DIAG;
         diag_one_en_ff <= `SLSD_RST_DIAG;
         lower_velocity_limit_ff <= `SLSD_RST_VEL;
         upper_velocity_limit_ff <= `SLSD_RST_VEL;
      end else if (REG_WR_I) begin
         case (REG_ADDR_I)
            `SLSD_ADDR_CTRL: begin
               stall_threshold_ff <= REG_WDATA_I[`SLSD_CTRL_THR_MSB:`SLSD_CTRL_THR_LSB];
               filt_en_ff <= REG_WDATA_I[`SLSD_CTRL_FILT_BIT];
               diag_zero_en_ff <= REG_WDATA_I[`SLSD_CTRL_DIAG_ZERO_BIT];
               diag_one_en_ff <= REG_WDATA_I[`SLSD_CTRL_DIAG_ONE_BIT];
            end
            `SLSD_ADDR_LOWER_VEL: begin
               lower_velocity_limit_ff <= REG_WDATA_I[VEL_W-1:0];
            end
            `SLSD_ADDR_UPPER_VEL: begin
               upper_velocity_limit_ff <= REG_WDATA_I[VEL_W-1:0];
            end
            default: begin
               lower_velocity_limit_ff <= lower_velocity_limit_ff;
            end
         endcase
      end
   end

   // stall decision; zero result inside the window raises it
   always @* begin
      nxt_stall = stall_ff;
      if (!in_window) begin
         nxt_stall = 1'b0;
      end else if (filt_valid) begin
         nxt_stall = (filt_data == {LOAD_W{1'b0}});
      end
   end

   // result, stall and diagnostic pins all move on one edge
   always @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         load_result_ff <= `SLSD_RST_LOAD;
         stall_ff <= 1'b0;
         diag_zero_ff <= 1'b0;
         diag_one_ff <= 1'b0;
      end else begin
         if (filt_valid) begin
            load_result_ff <= filt_data;
         end
         stall_ff <= nxt_stall;
         diag_zero_ff <= nxt_stall && diag_zero_en_ff;
         diag_one_ff <= nxt_stall && diag_one_en_ff;
      end
   end

   // read mux; data stands only in the cycle after the strobe
   always @* begin
      nxt_rdata = 32'h00000000;
      if (REG_RD_I) begin
         case (REG_ADDR_I)
            `SLSD_ADDR_CTRL: begin
               nxt_rdata[`SLSD_CTRL_THR_MSB:`SLSD_CTRL_THR_LSB] = stall_threshold_ff;
               nxt_rdata[`SLSD_CTRL_FILT_BIT] = filt_en_ff;
               nxt_rdata[`SLSD_CTRL_DIAG_ZERO_BIT] = diag_zero_en_ff;
               nxt_rdata[`SLSD_CTRL_DIAG_ONE_BIT] = diag_one_en_ff;
            end
            `SLSD_ADDR_LOWER_VEL: begin
               nxt_rdata[VEL_W-1:0] = lower_velocity_limit_ff;
            end
            `SLSD_ADDR_UPPER_VEL: begin
               nxt_rdata[VEL_W-1:0] = upper_velocity_limit_ff;
            end
            `SLSD_ADDR_STATUS: begin
               nxt_rdata[`SLSD_STAT_LOAD_MSB:`SLSD_STAT_LOAD_LSB] = load_result_ff;
               nxt_rdata[`SLSD_STAT_STALL_BIT] = stall_ff;
            end
            `SLSD_ADDR_INTERVAL: begin
               nxt_rdata[VEL_W-1:0] = step_interval_measure;
            end
            default: begin
               nxt_rdata = 32'h00000000; // unmapped reads as zero
            end
         endcase
      end
   end

   always @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rdata_ff <= 32'h00000000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign REG_RDATA_O = rdata_ff;
   assign LOAD_RESULT_O = load_result_ff;
   assign STALL_O = stall_ff;
   assign DIAG_OUT_ZERO_O = diag_zero_ff;
   assign DIAG_OUT_ONE_O = diag_one_ff;

endmodule // sensorless_load_stall_detect
`default_nettype wire

// ### src/step_interval_meter.v
// step interval meter: time between full steps in divider ticks
// assumes fullstep_i is a one-cycle pulse from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "sensorless_load_stall_detect_consts.vh"

module step_interval_meter #(
   parameter TICK_DIV = `SLSD_TICK_DIV,
   parameter VEL_W = `SLSD_VEL_W
) (
   input wire clk_i, // block clock
   input wire rst_b_i, // async reset, active low
   input wire fullstep_i, // one pulse per full step
   output wire [VEL_W-1:0] interval_o // ticks per full step
);

   reg [7:0] div_ff;
   reg tick_ff;
   reg [VEL_W-1:0] run_ff;
   reg [VEL_W-1:0] last_ff;
   wire [VEL_W-1:0] all_ones;

   assign all_ones = {VEL_W{1'b1}};

   // divider gives a one-cycle tick enable, keeps the counter narrow
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_ff <= 8'h00;
         tick_ff <= 1'b0;
      end else if (div_ff == TICK_DIV[7:0] - 8'h01) begin
         div_ff <= 8'h00;
         tick_ff <= 1'b1;
      end else begin
         div_ff <= div_ff + 8'h01;
         tick_ff <= 1'b0;
      end
   end

   // running count latched on every full step, saturates when stopped
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run_ff <= {VEL_W{1'b0}};
         last_ff <= {VEL_W{1'b1}};
      end else if (fullstep_i) begin
         last_ff <= run_ff;
         run_ff <= {VEL_W{1'b0}};
      end else if (tick_ff && run_ff != all_ones) begin
         run_ff <= run_ff + {{(VEL_W-1){1'b0}}, 1'b1};
      end
   end

   // a slowing motor shows its longer running count before the next step
   assign interval_o = (run_ff > last_ff) ? run_ff : last_ff;

endmodule // step_interval_meter
`default_nettype wire

// ### test/motion_ctrl_model.sv
// motion controller model: full steps while run, halts on a stall
// assumes run, sample and stop enable come from the bench on this clock
`timescale 1ns/100ps
`default_nettype none
module motion_ctrl_model #(
   parameter PERIOD = 20
) (
   input wire logic clk_i, // clock
   input wire logic rst_b_i, // reset, active low
   input wire logic run_i, // move while high
   input wire logic stop_en_i, // halt on stall
   input wire logic [9:0] raw_i, // next load sample
   input wire logic stall_i, // stall from detector
   output logic fullstep_o, // step strobe
   output logic [9:0] raw_load_o // sample with strobe
);
   int cnt;
   logic halt_ff;
   // sample toggles between strobes so a stale value is never trusted
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt <= 0;
         halt_ff <= 1'b0;
         fullstep_o <= 1'b0;
         raw_load_o <= 10'h000;
      end else begin
         halt_ff <= run_i && (halt_ff || (stop_en_i && stall_i));
         fullstep_o <= run_i && !halt_ff && cnt == PERIOD - 1;
         cnt <= (run_i && cnt < PERIOD - 1) ? cnt + 1 : 0;
         raw_load_o <= (cnt == PERIOD - 1) ? raw_i : ~raw_load_o;
      end
   end
endmodule // motion_ctrl_model
`default_nettype wire

// ### test/sensorless_load_stall_detect_asserts.sv
// checker for load result, stall and diagnostic outputs
// assumes binding into the detector top; sees its ports only
`timescale 1ns/100ps
`default_nettype none
module sensorless_load_stall_detect_asserts #(
   parameter LOAD_W = 10
) (
   input wire logic CLK_I, // clock
   input wire logic RST_B_I, // reset, active low
   input wire logic [2:0] REG_ADDR_I, // address
   input wire logic [31:0] REG_WDATA_I, // write data
   input wire logic REG_WR_I, // write strobe
   input wire logic FULLSTEP_I, // step strobe
   input wire logic [LOAD_W-1:0] RAW_LOAD_I, // raw sample
   input wire logic DIAG_OUT_ZERO_O, // diag zero
   input wire logic DIAG_OUT_ONE_O, // diag one
   input wire logic [LOAD_W-1:0] LOAD_RESULT_O, // result
   input wire logic STALL_O // stall
);
   logic [10:0] ctrl_ff;
   logic [19:0] lo_ff;
   logic [19:0] hi_ff;
   logic [1:0] cnt_ff;
   logic signed [12:0] sum;
   logic [LOAD_W-1:0] want;
   wire wr_ctrl = REG_WR_I && REG_ADDR_I == 3'h0;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   // shadow of settings; a control write that changes the filter bit restarts the filter group
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ctrl_ff <= 11'h000;
         lo_ff <= 20'h00000;
         hi_ff <= 20'h00000;
         cnt_ff <= 2'h0;
      end else begin
         if (wr_ctrl) ctrl_ff <= REG_WDATA_I[10:0];
         if (REG_WR_I && REG_ADDR_I == 3'h1) lo_ff <= REG_WDATA_I[19:0];
         if (REG_WR_I && REG_ADDR_I == 3'h2) hi_ff <= REG_WDATA_I[19:0];
         cnt_ff <= (wr_ctrl && REG_WDATA_I[8] != ctrl_ff[8]) ? 2'h0 : cnt_ff + {1'b0, FULLSTEP_I};
      end
   end
   // raw sample offset by eight per threshold step, then clamped
   assign sum = $signed({3'h0, RAW_LOAD_I}) + $signed(ctrl_ff[6:0]) * 13'sh008;
   assign want = sum < 0 ? '0 : (sum > 13'sh3FF ? '1 : sum[LOAD_W-1:0]);
   sequence s_raw_step;
      FULLSTEP_I && !ctrl_ff[8];
   endsequence
   sequence s_empty_win;
      (lo_ff < hi_ff) [*3];
   endsequence
   a_thr_offset: assert property (s_raw_step |=> LOAD_RESULT_O == $past(want))
      else $error("load result differs from offset sample");
   a_step_refresh: assert property ($changed(LOAD_RESULT_O) |-> $past(FULLSTEP_I))
      else $error("load result changed without a step");
   a_filter_group: assert property (ctrl_ff[8] && $changed(LOAD_RESULT_O) |-> cnt_ff == 2'h0)
      else $error("filtered result not on fourth step");
   a_stall_zero: assert property (STALL_O |-> LOAD_RESULT_O == '0)
      else $error("stall with nonzero load result");
   a_diag_zero: assert property ($stable(ctrl_ff[9]) |-> DIAG_OUT_ZERO_O == (STALL_O && ctrl_ff[9]))
      else $error("diag zero does not follow stall");
   a_diag_one: assert property ($stable(ctrl_ff[10]) |-> DIAG_OUT_ONE_O == (STALL_O && ctrl_ff[10]))
      else $error("diag one does not follow stall");
   a_empty_window: assert property (s_empty_win |-> !STALL_O)
      else $error("stall outside velocity window");
   a_stall_release: assert property (STALL_O && REG_WR_I && REG_ADDR_I == 3'h1
      && REG_WDATA_I[19:0] == 20'h00000 |-> ##[1:3] !STALL_O)
      else $error("stall held after window exit");
endmodule // sensorless_load_stall_detect_asserts
bind sensorless_load_stall_detect sensorless_load_stall_detect_asserts #(.LOAD_W(LOAD_W)) chk_i (
   .CLK_I(CLK_I), .RST_B_I(RST_B_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
   .REG_WR_I(REG_WR_I), .FULLSTEP_I(FULLSTEP_I), .RAW_LOAD_I(RAW_LOAD_I),
   .DIAG_OUT_ZERO_O(DIAG_OUT_ZERO_O), .DIAG_OUT_ONE_O(DIAG_OUT_ONE_O),
   .LOAD_RESULT_O(LOAD_RESULT_O), .STALL_O(STALL_O));
`default_nettype wire

// ### test/sensorless_load_stall_detect_tb_top.sv
// self-checking bench for the load and stall detector
// assumes detector, checker and controller model are compiled first
`timescale 1ns/100ps
`default_nettype none
module sensorless_load_stall_detect_tb_top;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic run = 1'b0;
   logic stop_en = 1'b0;
   logic [9:0] raw = 10'h000;
   wire [31:0] rdata;
   wire fullstep;
   wire [9:0] raw_load;
   wire diag_zero;
   wire diag_one;
   wire stall;
   wire [9:0] load;
   int n_errors = 0;
   int n_checks = 0;
   // 200 MHz
   always #2.5 clk = ~clk;
   // short tick divider makes the interval counts eight times larger than the default
   sensorless_load_stall_detect #(.TICK_DIV(2)) sensorless_load_stall_detect_i (
      .CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .FULLSTEP_I(fullstep),
      .RAW_LOAD_I(raw_load), .DIAG_OUT_ZERO_O(diag_zero), .DIAG_OUT_ONE_O(diag_one),
      .LOAD_RESULT_O(load), .STALL_O(stall));
   motion_ctrl_model motion_ctrl_model_i (.clk_i(clk), .rst_b_i(rst_b), .run_i(run),
      .stop_en_i(stop_en), .raw_i(raw), .stall_i(stall), .fullstep_o(fullstep),
      .raw_load_o(raw_load));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [2:0] a, input logic [31:0] want, input string what);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(what, rdata, want);
   endtask
   // n steps with the given samples, then stop and let outputs settle
   task automatic steps(input logic [9:0] a, b, c, input int n);
      logic [9:0] r [3];
      int k;
      r = '{a, b, c};
      for (int i = 0; i < n; i++) begin
         raw <= r[i];
         run <= 1'b1;
         k = 0;
         do begin
            @(posedge clk);
            k++;
         end while (fullstep !== 1'b1 && k < 100);
         if (k >= 100) chk("step wait", 32'h0, 32'h1);
      end
      run <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic t_reset;
      rd_chk(3'h0, 32'h0, "ctrl");
      rd_chk(3'h3, 32'h0, "status");
      rd_chk(3'h5, 32'h0, "unmapped");
      rd_chk(3'h4, 32'h000FFFFF, "interval");
   endtask
   // thresholds incl. both clamps; upper above lower keeps window empty
   task automatic t_thr;
      logic [6:0] thr [5] = '{7'h00, 7'h73, 7'h05, 7'h3F, 7'h40};
      logic [9:0] rw [5] = '{10'h064, 10'h064, 10'h064, 10'h3E8, 10'h3FF};
      logic [9:0] ld [5] = '{10'h064, 10'h000, 10'h08C, 10'h3FF, 10'h1FF};
      wr_reg(3'h2, 32'h1);
      for (int i = 0; i < 5; i++) begin
         wr_reg(3'h0, {25'h0, thr[i]});
         steps(rw[i], 10'h000, 10'h000, 1);
         chk("load", 32'(load), 32'(ld[i]));
         chk("stall off", 32'(stall), 32'h0);
         rd_chk(3'h3, {22'h0, ld[i]}, "status");
      end
   endtask
   task automatic t_filt;
      wr_reg(3'h0, 32'h100);
      steps(10'h00A, 10'h014, 10'h01E, 3);
      chk("load held", 32'(load), 32'h1FF);
      steps(10'h029, 10'h000, 10'h000, 1);
      chk("load mean", 32'(load), 32'h019);
      wr_reg(3'h0, 32'h0);
   endtask
   task automatic t_window;
      wr_reg(3'h1, 32'h3E8);
      rd_chk(3'h1, 32'h3E8, "lower limit");
      for (int s = 0; s < 2; s++) begin
         wr_reg(3'h0, s ? 32'h400 : 32'h200);
         rd_chk(3'h0, s ? 32'h400 : 32'h200, "ctrl");
         steps(10'h1F4, 10'h1F4, 10'h000, 3);
         chk("diag zero", 32'(diag_zero), 32'(s == 0));
         chk("diag one", 32'(diag_one), 32'(s == 1));
         rd_chk(3'h3, 32'h10000, "status stall");
         steps(10'h12C, 10'h000, 10'h000, 1);
         chk("stall drop", 32'({stall, diag_zero, diag_one}), 32'h0);
         // status is read-only: a write must leave the result untouched
         wr_reg(3'h3, 32'hFFFFFFFF);
         rd_chk(3'h3, 32'h12C, "status read-only");
      end
      wr_reg(3'h1, 32'h5);
      steps(10'h1F4, 10'h000, 10'h000, 2);
      chk("slow stall", 32'(stall), 32'h0);
      wr_reg(3'h1, 32'h3E8);
      wr_reg(3'h2, 32'h32);
      rd_chk(3'h2, 32'h32, "upper limit");
      steps(10'h000, 10'h000, 10'h000, 1);
      chk("fast stall", 32'(stall), 32'h0);
   endtask
   task automatic t_stop;
      int k;
      wr_reg(3'h2, 32'h1);
      stop_en <= 1'b1;
      steps(10'h1F4, 10'h000, 10'h000, 2);
      run <= 1'b1;
      k = 0;
      repeat (100) begin
         @(posedge clk);
         k += fullstep;
      end
      chk("steps after stall", 32'(k), 32'h0);
      wr_reg(3'h1, 32'h0);
      repeat (3) @(posedge clk);
      #1 chk("stall exit", 32'(stall), 32'h0);
      run <= 1'b0;
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // reset, scenarios, verdict
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      t_reset;
      t_thr;
      t_filt;
      t_window;
      t_stop;
      report_and_stop;
   end
   // watchdog well past the expected several hundred cycles
   initial begin
      #100us;
      n_errors++;
      report_and_stop;
   end
endmodule // sensorless_load_stall_detect_tb_top
`default_nettype wire
